// ---- sfwp_defs.vh ----
`ifndef SFWP_DEFS_VH
`define SFWP_DEFS_VH

// array geometry
`define SFWP_ADDR_W 24
`define SFWP_SEC_HI 23
`define SFWP_SEC_LO 16
`define SFWP_SECTORS 9'h100
`define SFWP_SECTOR_BITS 256
`define SFWP_SUBSEC_MASK 24'hfff000
`define SFWP_SECTOR_MASK 24'hff0000
`define SFWP_PAGE_HI 23
`define SFWP_PAGE_LO 8
`define SFWP_ERASED 8'hff
`define SFWP_OTP_BYTES 64
`define SFWP_OTP_AW 6

// block protect decode
`define SFWP_BP_NONE 4'h0
`define SFWP_BP_MAX 4'h8
`define SFWP_BP_ONE 4'h1
`define SFWP_SPAN_ONE 9'h001

// whole-byte check on the clock count
`define SFWP_BYTE_FRAC_HI 2
`define SFWP_BYTE_FRAC_LO 0

// host commands
`define SFWP_OP_WREN 4'h0
`define SFWP_OP_WRDI 4'h1
`define SFWP_OP_PROG 4'h2
`define SFWP_OP_SSE 4'h3
`define SFWP_OP_SE 4'h4
`define SFWP_OP_BE 4'h5
`define SFWP_OP_LOCKW 4'h6
`define SFWP_OP_STW 4'h7
`define SFWP_OP_OTPP 4'h8
`define SFWP_OP_OTPR 4'h9

// refusal causes
`define SFWP_CAUSE_OK 3'h0
`define SFWP_CAUSE_PART 3'h1
`define SFWP_CAUSE_NOWEL 3'h2
`define SFWP_CAUSE_PROT 3'h3
`define SFWP_CAUSE_LOCKED 3'h4
`define SFWP_CAUSE_WPLOCK 3'h5

// register port
`define SFWP_REG_STATUS 2'h0
`define SFWP_REG_SECSEL 2'h1
`define SFWP_REG_LOCKRD 2'h2
`define SFWP_REG_RESULT 2'h3

// status field layout
`define SFWP_ST_WEL 1
`define SFWP_ST_BP_HI 5
`define SFWP_ST_BP_LO 2
`define SFWP_ST_TB 6
`define SFWP_ST_WPL 7

// lock data layout
`define SFWP_LK_WR 0
`define SFWP_LK_DN 1

`endif

// ---- sfwp_otp.v ----
`include "sfwp_defs.vh"

module sfwp_otp (
    input wire ref_clk,
    input wire rst_n,
    input wire prog_en,
    input wire rd_en,
    input wire [`SFWP_OTP_AW-1:0] addr,
    input wire [7:0] wdata,
    output reg [7:0] rdata
);

    reg [7:0] mem [0:`SFWP_OTP_BYTES-1];
    integer i;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < `SFWP_OTP_BYTES; i = i + 1) begin
                mem[i] <= `SFWP_ERASED;
            end
            rdata <= 8'h00;
        end else begin
            // one-time area: programming only clears bits; only reset sets them all again
            if (prog_en) begin
                mem[addr] <= mem[addr] & wdata;
            end
            if (rd_en) begin
                rdata <= mem[addr];
            end
        end
    end

endmodule

// ---- sfwp_guard.v ----
// Added by the designer: the address map and the plain strobed port.
`include "sfwp_defs.vh"

module sfwp_guard (
    input wire ref_clk,
    input wire rst_n,
    input wire cmd_valid,
    input wire [3:0] cmd_op,
    input wire [`SFWP_ADDR_W-1:0] cmd_addr,
    input wire [15:0] cmd_clk_count,
    input wire [7:0] cmd_wdata,
    input wire [7:0] cmd_old,
    input wire cmd_quad,
    input wire wp_n_pin,
    input wire [1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg op_go,
    output reg [3:0] op_kind,
    output reg [`SFWP_ADDR_W-1:0] op_addr,
    output reg [15:0] op_page,
    output reg [7:0] op_data,
    output reg op_reject,
    output reg [2:0] op_cause,
    output wire [7:0] otp_rdata
);

    reg wp_meta;
    reg wp_sync;
    reg wel;
    reg [3:0] block_protect_level;
    reg top_bottom_select;
    reg [7:0] sec_sel;
    reg [2:0] last_cause;
    reg [`SFWP_SECTOR_BITS-1:0] lock_wr;
    reg [`SFWP_SECTOR_BITS-1:0] lock_dn;

    reg [7:0] sec;
    reg modify;
    reg array_op;
    reg sec_prot;
    reg bulk_blocked;
    reg [2:0] next_cause;
    reg accept;
    reg otp_prog;
    reg otp_rd;
    reg wp_lock;
    integer i;

    // block-protect decode for one sector
    function bp_hit;
        input [7:0] s;
        input [3:0] lvl;
        input tb;
        reg [8:0] span;
        begin
            span = `SFWP_SPAN_ONE << (lvl - `SFWP_BP_ONE);
            if (lvl == `SFWP_BP_NONE) begin
                bp_hit = 1'b0;
            end else if (lvl > `SFWP_BP_MAX) begin
                bp_hit = 1'b1;
            end else if (tb) begin
                bp_hit = ({1'b0, s} < span);
            end else begin
                bp_hit = ({1'b0, s} >= (`SFWP_SECTORS - span));
            end
        end
    endfunction

    // a sector is writable only if both protections leave it open
    function sector_blocked;
        input [7:0] s;
        input [3:0] lvl;
        input tb;
        input lk;
        begin
            sector_blocked = bp_hit(s, lvl, tb) | lk;
        end
    endfunction

    sfwp_otp u_otp (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .prog_en(otp_prog),
        .rd_en(otp_rd),
        .addr(cmd_addr[`SFWP_OTP_AW-1:0]),
        .wdata(cmd_wdata),
        .rdata(otp_rdata)
    );

    // write-protect pin crosses in from outside the clock domain
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_meta <= 1'b1;
            wp_sync <= 1'b1;
        end else begin
            wp_meta <= wp_n_pin;
            wp_sync <= wp_meta;
        end
    end

    always @* begin
        // in quad mode the pin carries data, so it cannot protect
        wp_lock = ~wp_sync & ~cmd_quad;
        sec = cmd_addr[`SFWP_SEC_HI:`SFWP_SEC_LO];
        modify = (cmd_op == `SFWP_OP_PROG) | (cmd_op == `SFWP_OP_SSE) |
                 (cmd_op == `SFWP_OP_SE) | (cmd_op == `SFWP_OP_BE) |
                 (cmd_op == `SFWP_OP_LOCKW) | (cmd_op == `SFWP_OP_STW) |
                 (cmd_op == `SFWP_OP_OTPP);
        // page, subsector and sector all fall inside one sector
        array_op = (cmd_op == `SFWP_OP_PROG) | (cmd_op == `SFWP_OP_SSE) |
                   (cmd_op == `SFWP_OP_SE);
        sec_prot = sector_blocked(sec, block_protect_level,
                                  top_bottom_select, lock_wr[sec]);
        bulk_blocked = 1'b0;
        for (i = 0; i < `SFWP_SECTOR_BITS; i = i + 1) begin
            if (sector_blocked(i[7:0], block_protect_level,
                               top_bottom_select, lock_wr[i])) begin
                bulk_blocked = 1'b1;
            end
        end
        next_cause = `SFWP_CAUSE_OK;
        if (modify) begin
            if (cmd_clk_count[`SFWP_BYTE_FRAC_HI:`SFWP_BYTE_FRAC_LO]
                    != 3'h0) begin
                next_cause = `SFWP_CAUSE_PART;
            end else if (!wel) begin
                next_cause = `SFWP_CAUSE_NOWEL;
            end else if (array_op && sec_prot) begin
                next_cause = `SFWP_CAUSE_PROT;
            end else if ((cmd_op == `SFWP_OP_BE) && bulk_blocked) begin
                next_cause = `SFWP_CAUSE_PROT;
            end else if ((cmd_op == `SFWP_OP_LOCKW) && lock_dn[sec]) begin
                next_cause = `SFWP_CAUSE_LOCKED;
            end else if ((cmd_op == `SFWP_OP_STW) && wp_lock) begin
                next_cause = `SFWP_CAUSE_WPLOCK;
            end
        end
        accept = cmd_valid & modify & (next_cause == `SFWP_CAUSE_OK);
        otp_prog = accept & (cmd_op == `SFWP_OP_OTPP);
        otp_rd = cmd_valid & (cmd_op == `SFWP_OP_OTPR);
    end

    // command decision and protection state
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wel <= 1'b0;
            block_protect_level <= 4'h0;
            top_bottom_select <= 1'b0;
            lock_wr <= {`SFWP_SECTOR_BITS{1'b0}};
            lock_dn <= {`SFWP_SECTOR_BITS{1'b0}};
            last_cause <= `SFWP_CAUSE_OK;
            op_go <= 1'b0;
            op_kind <= 4'h0;
            op_addr <= {`SFWP_ADDR_W{1'b0}};
            op_page <= 16'h0000;
            op_data <= 8'h00;
            op_reject <= 1'b0;
            op_cause <= `SFWP_CAUSE_OK;
        end else begin
            op_go <= 1'b0;
            op_reject <= 1'b0;
            if (cmd_valid) begin
                op_kind <= cmd_op;
                op_cause <= next_cause;
                op_page <= cmd_addr[`SFWP_PAGE_HI:`SFWP_PAGE_LO];
                if (cmd_op == `SFWP_OP_WREN) begin
                    wel <= 1'b1;
                end else if (cmd_op == `SFWP_OP_WRDI) begin
                    wel <= 1'b0;
                end
                if (modify) begin
                    last_cause <= next_cause;
                    op_reject <= ~accept;
                end
                if (accept) begin
                    // latch is spent by each command it lets through
                    wel <= 1'b0;
                end
                // only array work and OTP programs leave the block as an operation
                op_go <= accept & (array_op | (cmd_op == `SFWP_OP_BE) |
                                   (cmd_op == `SFWP_OP_OTPP));
                case (cmd_op)
                    `SFWP_OP_PROG: begin
                        op_addr <= cmd_addr;
                        op_data <= cmd_old & cmd_wdata;
                    end
                    `SFWP_OP_SSE: begin
                        op_addr <= cmd_addr & `SFWP_SUBSEC_MASK;
                        op_data <= `SFWP_ERASED;
                    end
                    `SFWP_OP_SE: begin
                        op_addr <= cmd_addr & `SFWP_SECTOR_MASK;
                        op_data <= `SFWP_ERASED;
                    end
                    `SFWP_OP_BE: begin
                        op_addr <= {`SFWP_ADDR_W{1'b0}};
                        op_data <= `SFWP_ERASED;
                    end
                    `SFWP_OP_OTPP: begin
                        op_addr <= cmd_addr;
                        op_data <= cmd_old & cmd_wdata;
                    end
                    default: begin
                        op_addr <= cmd_addr;
                        op_data <= cmd_wdata;
                    end
                endcase
                if (accept && (cmd_op == `SFWP_OP_LOCKW)) begin
                    lock_wr[sec] <= cmd_wdata[`SFWP_LK_WR];
                    // lock-down is sticky until reset
                    lock_dn[sec] <= lock_dn[sec] |
                                    cmd_wdata[`SFWP_LK_DN];
                end
            end
            if (accept && (cmd_op == `SFWP_OP_STW)) begin
                block_protect_level <=
                    cmd_wdata[`SFWP_ST_BP_HI:`SFWP_ST_BP_LO];
                top_bottom_select <= cmd_wdata[`SFWP_ST_TB];
            end else if (reg_wr && (reg_addr == `SFWP_REG_STATUS) &&
                         !wp_lock) begin
                // software path obeys the same pin freeze
                block_protect_level <=
                    reg_wdata[`SFWP_ST_BP_HI:`SFWP_ST_BP_LO];
                top_bottom_select <= reg_wdata[`SFWP_ST_TB];
            end
        end
    end

    // register port: read data stands in the cycle after the strobe
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_sel <= 8'h00;
            reg_rdata <= 8'h00;
        end else begin
            if (reg_wr && (reg_addr == `SFWP_REG_SECSEL)) begin
                sec_sel <= reg_wdata;
            end
            if (reg_rd) begin
                case (reg_addr)
                    `SFWP_REG_STATUS: begin
                        reg_rdata <= {wp_lock, top_bottom_select,
                                      block_protect_level, wel, 1'b0};
                    end
                    `SFWP_REG_SECSEL: begin
                        reg_rdata <= sec_sel;
                    end
                    `SFWP_REG_LOCKRD: begin
                        reg_rdata <= {6'h00, lock_dn[sec_sel],
                                      lock_wr[sec_sel]};
                    end
                    `SFWP_REG_RESULT: begin
                        reg_rdata <= {5'h00, last_cause};
                    end
                    default: begin
                        reg_rdata <= 8'h00;
                    end
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

endmodule

// ---- sfwp_guard_props.sv ----
module sfwp_guard_props (
    input wire ref_clk,
    input wire rst_n,
    input wire cmd_valid,
    input wire [3:0] cmd_op,
    input wire [23:0] cmd_addr,
    input wire [15:0] cmd_clk_count,
    input wire [7:0] cmd_wdata,
    input wire [7:0] cmd_old,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire op_go,
    input wire [23:0] op_addr,
    input wire [7:0] op_data,
    input wire op_reject,
    input wire [2:0] op_cause
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire mod = cmd_valid && cmd_op >= 4'h2 && cmd_op <= 4'h8;
    wire whole = cmd_clk_count[2:0] == 3'h0;
    wire ers = cmd_valid && cmd_op >= 4'h3 && cmd_op <= 4'h5;
    sequence s_wren;
        cmd_valid && cmd_op == 4'h0;
    endsequence
    sequence s_prog;
        cmd_valid && cmd_op == 4'h2 && whole;
    endsequence
    a_partial_refused: assert property (
        mod && !whole |=> op_reject && !op_go && op_cause == 3'h1)
        else $error("partial byte command not refused");
    a_prog_clears: assert property (
        cmd_valid && cmd_op == 4'h2 |=>
        op_data == ($past(cmd_old) & $past(cmd_wdata)))
        else $error("program data not old and new");
    a_erase_ones: assert property (ers |=> op_data == 8'hff)
        else $error("erase data not all ones");
    a_subsec_align: assert property (
        cmd_valid && cmd_op == 4'h3 |=>
        op_addr == ($past(cmd_addr) & 24'hfff000))
        else $error("subsector address not aligned");
    a_latch_quiet: assert property (
        cmd_valid && cmd_op <= 4'h1 |=> !op_go && !op_reject)
        else $error("latch command answered");
    a_wren_enables: assert property (
        s_wren ##1 s_prog |=> op_cause != 3'h2)
        else $error("program refused after latch set");
    a_go_clean: assert property (
        op_go |-> op_cause == 3'h0 && !op_reject && $past(mod))
        else $error("go without accepted modify");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule

// ---- sfwp_host.sv ----
module sfwp_host (
    input wire ref_clk,
    output reg cmd_valid,
    output reg [3:0] cmd_op,
    output reg [23:0] cmd_addr,
    output reg [15:0] cmd_clk_count,
    output reg [7:0] cmd_wdata,
    output reg [7:0] cmd_old
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cmd_valid, cmd_op, cmd_addr, cmd_clk_count} = '0;
        {cmd_wdata, cmd_old} = '0;
    end
    task send(input [3:0] op, input [23:0] a, input [15:0] n,
              input [7:0] d, input [7:0] o);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_clk_count <= n;
        cmd_wdata <= d;
        cmd_old <= o;
        @(posedge ref_clk);
    endtask
    // released fields flip so stale values cannot pass
    task rest;
        cmd_valid <= 1'b0;
        cmd_addr <= ~cmd_addr;
        cmd_wdata <= ~cmd_wdata;
        cmd_old <= ~cmd_old;
        cmd_clk_count <= ~cmd_clk_count;
    endtask
    task cmd(input [3:0] op, input [23:0] a, input [7:0] d, input [7:0] o);
        send(op, a, 16'h0020, d, o);
        rest;
    endtask
    task mod_cmd(input [3:0] op, input [23:0] a, input [7:0] d);
        send(4'h0, a, 16'h0008, 8'h00, 8'h00);
        cmd(op, a, d, 8'hff);
    endtask
endmodule

// ---- sfwp_guard_tb.sv ----
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
    errors++; $display("[FAIL] %s exp %0h got %0h", nm, e, s); end end
module sfwp_guard_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_n, cmd_quad, wp_n_pin, reg_wr, reg_rd, op_go;
    logic op_reject, cmd_valid;
    logic [1:0] reg_addr;
    logic [2:0] op_cause;
    logic [3:0] cmd_op, op_kind;
    logic [7:0] reg_wdata, reg_rdata, op_data, cmd_wdata, cmd_old, d;
    logic [7:0] otp_rdata;
    logic [15:0] op_page, cmd_clk_count;
    logic [23:0] op_addr, cmd_addr;
    int errors = 0, n_compared = 0;
    sfwp_host u_sfwp_host (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_old(cmd_old),
        .cmd_clk_count(cmd_clk_count), .cmd_wdata(cmd_wdata));
    sfwp_guard u_sfwp_guard (.ref_clk(ref_clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_clk_count(cmd_clk_count), .cmd_wdata(cmd_wdata),
        .cmd_old(cmd_old), .cmd_quad(cmd_quad), .wp_n_pin(wp_n_pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_go(op_go),
        .op_kind(op_kind), .op_addr(op_addr), .op_page(op_page),
        .op_data(op_data), .op_reject(op_reject), .op_cause(op_cause),
        .otp_rdata(otp_rdata));
    initial begin
        ref_clk = 0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task tally_and_finish;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wr(input [1:0] a, input [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task rd(input [1:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge ref_clk);
    endtask
    task res(input bit go, input [2:0] cause);
        #1;
        `CHK("op_go", go, op_go)
        `CHK("op_reject", !go && cause != 0, op_reject)
        `CHK("op_cause", cause, op_cause)
        @(posedge ref_clk);
    endtask
    task try_se(input int s, input bit ok);
        u_sfwp_host.mod_cmd(4'h4, {s[7:0], 16'h1234}, 8'h00);
        res(ok, ok ? 3'h0 : 3'h3);
        if (ok) `CHK("se_addr", {s[7:0], 16'h0000}, op_addr)
    endtask
    task t_protect;
        int n;
        for (int t = 0; t < 2; t++) begin
            for (int l = 0; l < 16; l++) begin
                n = l == 0 ? 0 : l > 8 ? 256 : 1 << (l - 1);
                wr(2'h0, {1'b0, t[0], l[3:0], 2'b00});
                if (n > 0) try_se(t ? n - 1 : 256 - n, 0);
                if (n < 256) try_se(t ? n : 255 - n, 1);
            end
        end
        wr(2'h0, 8'h00);
    endtask
    task t_prog;
        u_sfwp_host.cmd(4'h2, 24'h123456, 8'h0f, 8'hf5);
        res(0, 3'h2);
        u_sfwp_host.send(4'h0, 24'h0, 16'h0008, 8'h00, 8'h00);
        u_sfwp_host.send(4'h2, 24'h123456, 16'h001c, 8'h0f, 8'hf5);
        u_sfwp_host.rest;
        res(0, 3'h1);
        u_sfwp_host.cmd(4'h2, 24'h123456, 8'h0f, 8'hf5);
        res(1, 3'h0);
        `CHK("op_data", 8'h05, op_data)
        `CHK("op_page", 16'h1234, op_page)
        u_sfwp_host.cmd(4'h2, 24'h123456, 8'h0f, 8'hf5);
        res(0, 3'h2);
        u_sfwp_host.mod_cmd(4'h3, 24'h123456, 8'h00);
        res(1, 3'h0);
        `CHK("sse_addr", 24'h123000, op_addr)
        `CHK("sse_data", 8'hff, op_data)
        u_sfwp_host.mod_cmd(4'h5, 24'h123456, 8'h00);
        res(1, 3'h0);
        `CHK("be_addr", 24'h000000, op_addr)
    endtask
    task t_otp;
        u_sfwp_host.mod_cmd(4'h8, 24'h000005, 8'h3c);
        res(1, 3'h0);
        u_sfwp_host.cmd(4'h9, 24'h000005, 8'h00, 8'h00);
        res(0, 3'h0);
        `CHK("otp_rd", 8'h3c, otp_rdata)
        `CHK("op_kind", 4'h9, op_kind)
        u_sfwp_host.mod_cmd(4'h8, 24'h000005, 8'hf0);
        res(1, 3'h0);
        u_sfwp_host.cmd(4'h9, 24'h000005, 8'h00, 8'h00);
        res(0, 3'h0);
        `CHK("otp_and", 8'h30, otp_rdata)
        // latch set then dropped again before the program
        u_sfwp_host.send(4'h0, 24'h0, 16'h0008, 8'h00, 8'h00);
        u_sfwp_host.send(4'h1, 24'h0, 16'h0008, 8'h00, 8'h00);
        u_sfwp_host.cmd(4'h2, 24'h123456, 8'h0f, 8'hf5);
        res(0, 3'h2);
        rd(2'h3);
        `CHK("result", 8'h02, d)
        u_sfwp_host.mod_cmd(4'h2, 24'h654321, 8'h3c);
        res(1, 3'h0);
        `CHK("prog_data", 8'h3c, op_data)
    endtask
    task t_lock;
        u_sfwp_host.mod_cmd(4'h6, 24'h050000, 8'h01);
        res(0, 3'h0);
        try_se(5, 0);
        wr(2'h1, 8'h05);
        rd(2'h2);
        `CHK("lock", 8'h01, d)
        u_sfwp_host.mod_cmd(4'h6, 24'h050000, 8'h03);
        res(0, 3'h0);
        u_sfwp_host.mod_cmd(4'h6, 24'h050000, 8'h00);
        res(0, 3'h4);
        rd(2'h2);
        `CHK("lock_frozen", 8'h03, d)
        try_se(4, 1);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        wr(2'h1, 8'h05);
        rd(2'h2);
        `CHK("lock_reset", 8'h00, d)
        try_se(5, 1);
    endtask
    task t_wp;
        wp_n_pin <= 1'b0;
        repeat (3) @(posedge ref_clk);
        wr(2'h0, 8'h04);
        rd(2'h0);
        `CHK("status_wp", 8'h80, d)
        u_sfwp_host.mod_cmd(4'h7, 24'h0, 8'h04);
        res(0, 3'h5);
        // quad mode turns the pin into data, so no lock
        cmd_quad <= 1'b1;
        u_sfwp_host.cmd(4'h7, 24'h0, 8'h04, 8'h00);
        res(0, 3'h0);
        rd(2'h0);
        `CHK("status_quad", 8'h04, d)
        cmd_quad <= 1'b0;
        wp_n_pin <= 1'b1;
        // pin release needs the two sync stages first
        repeat (3) @(posedge ref_clk);
        wr(2'h0, 8'h00);
        rd(2'h0);
        `CHK("status_free", 8'h00, d)
    endtask
    initial begin
        {rst_n, cmd_quad, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        wp_n_pin = 1'b1;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(2'h0);
        `CHK("status_rst", 8'h00, d)
        t_prog;
        t_otp;
        t_protect;
        t_lock;
        t_wp;
        tally_and_finish;
    end
    initial begin
        #100000;
        errors++;
        tally_and_finish;
    end
endmodule
bind sfwp_guard sfwp_guard_props u_sfwp_guard_props (.ref_clk(ref_clk),
    .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_clk_count(cmd_clk_count),
    .cmd_wdata(cmd_wdata), .cmd_old(cmd_old), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .op_go(op_go), .op_addr(op_addr),
    .op_data(op_data), .op_reject(op_reject), .op_cause(op_cause));
